// file: design/i2c_ack_defs.svh
/*
 * Constants of the serial target byte and acknowledge engine.
 * Assumes inclusion by its bare name from the package and the engine.
 */
// Notes on behaviour
// - Any number of bytes may pass between a START and the next STOP, neither side sets a limit.
// - Every byte is eight data bits followed by exactly one acknowledge slot.
// - The sender of a byte releases the data line high during the acknowledge slot.
// - The addressed target acknowledges every byte it receives.
// - The acknowledging party holds the data line low over the whole high phase of the acknowledge clock.
// - After such a missing acknowledge the target stops driving and leaves the data line high for STOP.
// - START is a falling data line while the clock is high, STOP a rising data line while the clock is high.
// - Data changes only while the clock is low; changes while it is high are control conditions.
`ifndef I2C_ACK_DEFS_SVH
`define I2C_ACK_DEFS_SVH

`define I2CA_ADDR_W     7
`define I2CA_BYTE_W     8
`define I2CA_CNT_W      4
`define I2CA_BITS       4'h8
`define I2CA_ACK_MARK   4'h9
`define I2CA_RW_POS     0
`define I2CA_CNT_RST    4'h0
`define I2CA_BYTE_RST   8'h00

`endif

// file: design/i2c_ack_pkg.sv
/*
 * Types of the serial target byte and acknowledge engine.
 * Assumes the constants header is on the include path.
 */
`include "i2c_ack_defs.svh"

package i2c_ack_pkg;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_RX,
		ST_STALL,
		ST_ACK_RX,
		ST_LOAD,
		ST_TX,
		ST_TX_ACK
	} link_state_e;

	typedef logic [`I2CA_BYTE_W-1:0] byte_t;

	// State on the link clock: last sampled bit and its toggle
	typedef struct packed {
		logic bit_val;
		logic bit_tgl;
	} scl_side_s;

	// State on the system clock
	typedef struct packed {
		logic [1:0]              scl_sy;
		logic [1:0]              sda_sy;
		logic [1:0]              tgl_sy;
		logic                    scl_d;
		logic                    sda_d;
		logic                    tgl_d;
		logic [`I2CA_ADDR_W-1:0] addr_s1;
		logic [`I2CA_ADDR_W-1:0] addr_s2;
		link_state_e             st;
		logic [`I2CA_CNT_W-1:0]  cnt;
		byte_t                   sh;
		logic                    rw;
		logic                    nak;
		logic                    sda_oe;
		logic                    scl_oe;
		logic                    tx_ready;
		byte_t                   out_data;
		logic                    out_valid;
		byte_t                   sp_data;
		logic                    sp_valid;
		logic                    busy;
	} core_s;

endpackage : i2c_ack_pkg

// file: design/i2c_byte_acknowledge.sv
/*
 * Serial target byte engine: address match, byte reception and
 * transmission, acknowledge slot handling, two-entry receive buffer.
 * Assumes external pull-ups on both lines; the bench resolves each wire
 * from the output enables. The link clock is the serial clock pin itself.
 */
`timescale 1ns/1ps
`include "i2c_ack_defs.svh"

module i2c_byte_acknowledge
	import i2c_ack_pkg::*;
(
	input  wire logic                    clk_i,
	input  wire logic                    resetn_i,
	input  wire logic                    scl_clk_i,
	input  wire logic                    scl_i,
	input  wire logic                    sda_i,
	output logic                         scl_o,
	output logic                         scl_oe_o,
	output logic                         sda_o,
	output logic                         sda_oe_o,
	input  wire logic [`I2CA_ADDR_W-1:0] addr_i,
	output byte_t                        rx_data_o,
	output logic                         rx_valid_o,
	input  wire logic                    rx_ready_i,
	input  wire byte_t                   tx_data_i,
	input  wire logic                    tx_valid_i,
	output logic                         tx_ready_o,
	output logic                         busy_o
);

	logic [1:0] rst_sy_r;
	logic       rst_n;
	scl_side_s  lk_r;
	core_s      c_r;
	core_s      c_nxt;

	logic start_ev;
	logic stop_ev;
	logic fall_ev;
	logic bit_ev;
	logic push;
	logic pop;
	logic buf_full;

	// Reset released through two flops; assertion stays asynchronous
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_sy_r <= 2'h0;
		end else begin
			rst_sy_r <= {rst_sy_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sy_r[1];

	// Link side: data is sampled on the rising clock edge, where it is stable
	always_ff @(posedge scl_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			lk_r <= '0;
		end else begin
			lk_r.bit_val <= sda_i;
			lk_r.bit_tgl <= ~lk_r.bit_tgl;
		end
	end

	// Line events seen through the synchronisers
	assign start_ev = c_r.scl_sy[1] & c_r.scl_d & c_r.sda_d & ~c_r.sda_sy[1];
	assign stop_ev  = c_r.scl_sy[1] & c_r.scl_d & ~c_r.sda_d & c_r.sda_sy[1];
	assign fall_ev  = c_r.scl_d & ~c_r.scl_sy[1];
	// Toggle crossing; bit_val has been stable since the clock rose, two synchroniser flops earlier
	assign bit_ev   = c_r.tgl_d ^ c_r.tgl_sy[1];

	assign buf_full = c_r.out_valid & c_r.sp_valid;
	assign pop      = c_r.out_valid & rx_ready_i;

	// Whole protocol and receive buffer in one next-state process
	always_comb begin
		c_nxt = c_r;
		push  = 1'b0;
		c_nxt.scl_sy  = {c_r.scl_sy[0], scl_i};
		c_nxt.sda_sy  = {c_r.sda_sy[0], sda_i};
		c_nxt.tgl_sy  = {c_r.tgl_sy[0], lk_r.bit_tgl};
		c_nxt.scl_d   = c_r.scl_sy[1];
		c_nxt.sda_d   = c_r.sda_sy[1];
		c_nxt.tgl_d   = c_r.tgl_sy[1];
		c_nxt.addr_s1 = addr_i;
		c_nxt.addr_s2 = c_r.addr_s1;

		// Bits are counted per byte only, so bytes per frame are unbounded
		case (c_r.st)
			ST_IDLE: begin
				c_nxt.sda_oe = 1'b0;
			end
			ST_ADDR: begin
				if (bit_ev) begin
					c_nxt.sh  = {c_r.sh[`I2CA_BYTE_W-2:0], lk_r.bit_val};
					c_nxt.cnt = c_r.cnt + 4'h1;
				end
				if (fall_ev && c_r.cnt == `I2CA_BITS) begin
					if (c_r.sh[`I2CA_BYTE_W-1:1] == c_r.addr_s2) begin
						c_nxt.rw     = c_r.sh[`I2CA_RW_POS];
						c_nxt.sda_oe = 1'b1;
						c_nxt.st     = ST_ACK_ADDR;
					end else begin
						c_nxt.st = ST_IDLE; // slot left high, deaf until START
					end
				end
			end
			ST_ACK_ADDR: begin
				// Low held until the acknowledge clock falls again
				if (fall_ev) begin
					c_nxt.sda_oe = 1'b0;
					c_nxt.cnt    = `I2CA_CNT_RST;
					c_nxt.st     = c_r.rw ? ST_LOAD : ST_RX;
				end
			end
			ST_RX: begin
				if (bit_ev) begin
					c_nxt.sh  = {c_r.sh[`I2CA_BYTE_W-2:0], lk_r.bit_val};
					c_nxt.cnt = c_r.cnt + 4'h1;
				end
				// Ninth pulse is the acknowledge slot
				if (fall_ev && c_r.cnt == `I2CA_BITS) begin
					if (buf_full) begin
						c_nxt.st = ST_STALL;
					end else begin
						push         = 1'b1;
						c_nxt.sda_oe = 1'b1;
						c_nxt.st     = ST_ACK_RX;
					end
				end
			end
			ST_STALL: begin
				// Clock held low until one buffer entry is popped; no byte is lost
				if (!buf_full) begin
					push         = 1'b1;
					c_nxt.sda_oe = 1'b1;
					c_nxt.st     = ST_ACK_RX;
				end
			end
			ST_ACK_RX: begin
				if (fall_ev) begin
					c_nxt.sda_oe = 1'b0;
					c_nxt.cnt    = `I2CA_CNT_RST;
					c_nxt.st     = ST_RX;
				end
			end
			ST_LOAD: begin
				// Clock held low while waiting for the next byte to send
				if (tx_valid_i && c_r.tx_ready) begin
					c_nxt.sh     = tx_data_i;
					c_nxt.sda_oe = ~tx_data_i[`I2CA_BYTE_W-1]; // set while clock low
					c_nxt.cnt    = `I2CA_CNT_RST;
					c_nxt.st     = ST_TX;
				end
			end
			ST_TX: begin
				if (bit_ev) begin
					c_nxt.cnt = c_r.cnt + 4'h1;
				end
				if (fall_ev) begin
					if (c_r.cnt == `I2CA_BITS) begin
						c_nxt.sda_oe = 1'b0; // released for the master's answer
						c_nxt.st     = ST_TX_ACK;
					end else begin
						c_nxt.sh     = {c_r.sh[`I2CA_BYTE_W-2:0], 1'b0};
						c_nxt.sda_oe = ~c_r.sh[`I2CA_BYTE_W-2];
					end
				end
			end
			ST_TX_ACK: begin
				if (bit_ev) begin
					c_nxt.nak = lk_r.bit_val; // master acknowledges all but last
					c_nxt.cnt = `I2CA_ACK_MARK;
				end
				if (fall_ev && c_r.cnt == `I2CA_ACK_MARK) begin
					// Missing acknowledge: stay off the line until the next START
					c_nxt.st = c_r.nak ? ST_IDLE : ST_LOAD;
				end
			end
			default: begin
				c_nxt.st     = ST_IDLE;
				c_nxt.sda_oe = 1'b0;
			end
		endcase

		// Line conditions win over any byte in progress
		if (start_ev) begin
			c_nxt.st     = ST_ADDR;
			c_nxt.cnt    = `I2CA_CNT_RST;
			c_nxt.sda_oe = 1'b0;
			push         = 1'b0;
		end else if (stop_ev) begin
			c_nxt.st     = ST_IDLE;
			c_nxt.sda_oe = 1'b0;
			push         = 1'b0;
		end

		// One extra held cycle on leaving a stall lets data settle first
		c_nxt.scl_oe = (c_nxt.st == ST_STALL) | (c_nxt.st == ST_LOAD) |
			(c_r.st == ST_STALL && c_nxt.st == ST_ACK_RX) |
			(c_r.st == ST_LOAD && c_nxt.st == ST_TX);
		c_nxt.tx_ready = (c_nxt.st == ST_LOAD) & ~(c_r.st == ST_LOAD && tx_valid_i && c_r.tx_ready);
		// Busy registered so the port comes straight from a flop
		c_nxt.busy     = (c_nxt.st != ST_IDLE);

		// Two-entry buffer: head register feeds the port, spare catches a stall
		if (pop) begin
			if (c_r.sp_valid) begin
				c_nxt.out_data = c_r.sp_data;
				c_nxt.sp_valid = push;
				c_nxt.sp_data  = push ? c_r.sh : c_r.sp_data;
			end else begin
				c_nxt.out_valid = push;
				c_nxt.out_data  = push ? c_r.sh : c_r.out_data;
			end
		end else if (push) begin
			if (!c_r.out_valid) begin
				c_nxt.out_valid = 1'b1;
				c_nxt.out_data  = c_r.sh;
			end else begin
				c_nxt.sp_valid = 1'b1;
				c_nxt.sp_data  = c_r.sh;
			end
		end
	end

	// State register of the system clock domain, beside the two reset flops
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			c_r          <= '0;
			c_r.scl_sy   <= 2'h3;
			c_r.sda_sy   <= 2'h3;
			c_r.scl_d    <= 1'b1;
			c_r.sda_d    <= 1'b1;
			c_r.st       <= ST_IDLE;
			c_r.cnt      <= `I2CA_CNT_RST;
			c_r.sh       <= `I2CA_BYTE_RST;
			c_r.out_data <= `I2CA_BYTE_RST;
			c_r.sp_data  <= `I2CA_BYTE_RST;
		end else begin
			c_r <= c_nxt;
		end
	end

	// Open-drain lines only ever pull low
	assign scl_o      = 1'b0;
	assign sda_o      = 1'b0;
	assign scl_oe_o   = c_r.scl_oe;
	assign sda_oe_o   = c_r.sda_oe;
	assign rx_data_o  = c_r.out_data;
	assign rx_valid_o = c_r.out_valid;
	assign tx_ready_o = c_r.tx_ready;
	assign busy_o     = c_r.busy;

endmodule : i2c_byte_acknowledge

// file: sim/i2c_ack_checker.sv
/* Port assertions of the serial target engine.
 * Assumes a bind onto the engine top, ports by name. */
`timescale 1ns/1ps
module i2c_ack_checker
	import i2c_ack_pkg::*;
(
	input wire logic  clk_i,
	input wire logic  resetn_i,
	input wire logic  scl_i,
	input wire logic  scl_o,
	input wire logic  sda_o,
	input wire logic  scl_oe_o,
	input wire logic  sda_oe_o,
	input wire byte_t rx_data_o,
	input wire logic  rx_valid_o,
	input wire logic  rx_ready_i,
	input wire byte_t tx_data_i,
	input wire logic  tx_valid_i,
	input wire logic  tx_ready_o,
	input wire logic  busy_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// Byte hand-off, then first bit driven, then clock let go
	sequence s_take;
		tx_valid_i && tx_ready_o;
	endsequence
	sequence s_first_bit;
		(sda_oe_o == !$past(tx_data_i[7])) ##1 !scl_oe_o;
	endsequence
	// Clock rises since the last byte hand-off; reset loads all ones and the count stops there
	logic [3:0] tx_rise_r;
	logic       scl_q_r;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_rise_r <= 4'hF;
			scl_q_r   <= 1'b1;
		end else begin
			scl_q_r <= scl_i;
			if (tx_valid_i && tx_ready_o) begin
				tx_rise_r <= 4'h0;
			end else if (scl_i && !scl_q_r && tx_rise_r != 4'hF) begin
				tx_rise_r <= tx_rise_r + 4'h1;
			end
		end
	end
	chk_ack_release: assert property (tx_rise_r == 4'h8 && scl_i && !scl_q_r |-> !sda_oe_o)
		else $error("data line held in acknowledge slot");
	chk_open_drain: assert property (!scl_o && !sda_o)
		else $error("pin level not low");
	chk_sda_low: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("data pull changed with clock high");
	chk_stretch_low: assert property ($rose(scl_oe_o) |-> !scl_i)
		else $error("stretch began with clock high");
	chk_rx_hold: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
		else $error("stalled byte lost");
	chk_tx_drop: assert property (s_take |=> !tx_ready_o)
		else $error("ready held after take");
	chk_tx_msb: assert property (s_take |=> s_first_bit)
		else $error("first bit not msb");
	chk_idle_quiet: assert property (!busy_o && !$past(busy_o) |-> !sda_oe_o && !scl_oe_o)
		else $error("line pulled while idle");
	chk_rx_acked: assert property ($rose(rx_valid_o) |-> sda_oe_o)
		else $error("byte without acknowledge");
endmodule : i2c_ack_checker

bind i2c_byte_acknowledge i2c_ack_checker u_chk (.clk_i, .resetn_i, .scl_i, .scl_o, .sda_o, .scl_oe_o,
	.sda_oe_o, .rx_data_o, .rx_valid_o, .rx_ready_i, .tx_data_i, .tx_valid_i, .tx_ready_o, .busy_o);

// file: sim/i2c_master_model.sv
/* Bus master model: start, stop, byte write and read, 160 ns a bit.
 * Assumes the bench resolves both wires from the pull enables. */
`timescale 1ns/1ps
module i2c_master_model
	import i2c_ack_pkg::*;
(
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_oe_o,
	output logic      sda_oe_o
);
	// Lines released, clock still between frames
	initial begin
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
	end
	// Data set while low; stretch waited out, bounded
	task automatic bit_io(input logic b, output logic r);
		sda_oe_o = !b;
		#40;
		scl_oe_o = 1'b0;
		for (int i = 0; i < 5000 && !scl_i; i++) #8;
		#40 r = sda_i;
		#40 scl_oe_o = 1'b1;
		#40;
	endtask : bit_io
	// Offset keeps bus edges off the system clock edges
	task automatic start;
		#3 sda_oe_o = 1'b1;
		#80 scl_oe_o = 1'b1;
		#40;
	endtask : start
	task automatic stop;
		sda_oe_o = 1'b1;
		#40 scl_oe_o = 1'b0;
		#80 sda_oe_o = 1'b0;
		#80;
	endtask : stop
	task automatic wr_byte(input byte_t d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, ack);
	endtask : wr_byte
	task automatic rd_byte(input logic last, output byte_t d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask : rd_byte
endmodule : i2c_master_model

// file: sim/testbench.sv
/* Self-checking bench of the serial target engine.
 * Assumes the master model and the bound checker. */
`timescale 1ns/1ps
`include "i2c_ack_defs.svh"
`define CHK(n, e, g) checks_done++; if ((g) !== (e)) begin err_count++; $display("ERROR %s exp %0h got %0h", n, e, g); end
module testbench
	import i2c_ack_pkg::*;
;
	localparam logic [`I2CA_ADDR_W-1:0] OWN_ADDR = 7'h3A;
	logic                    clk_i, resetn_i, rx_ready_i, tx_valid_i, drain;
	logic                    m_scl_oe, m_sda_oe, scl_oe_o, sda_oe_o, rx_valid_o, tx_ready_o, busy_o;
	wire                     scl_w, sda_w;
	byte_t                   rx_data_o, tx_data_i;
	logic [`I2CA_ADDR_W-1:0] addr_i;
	byte_t                   got[$];
	byte_t                   rdv[4] = '{8'h80, 8'h7E, 8'hC3, 8'h00};
	logic [1:0]              ti;
	int                      err_count, checks_done, cyc;
	// Pull-ups win unless someone pulls low
	assign scl_w = !(m_scl_oe || scl_oe_o);
	assign sda_w = !(m_sda_oe || sda_oe_o);
	i2c_byte_acknowledge uut (.clk_i(clk_i), .resetn_i(resetn_i), .scl_clk_i(scl_w), .scl_i(scl_w),
		.sda_i(sda_w), .scl_o(), .scl_oe_o(scl_oe_o), .sda_o(), .sda_oe_o(sda_oe_o), .addr_i(addr_i),
		.rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .tx_data_i(tx_data_i),
		.tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .busy_o(busy_o));
	i2c_master_model m (.scl_i(scl_w), .sda_i(sda_w), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// Consumer, byte source and hang limit
	always @(posedge clk_i) begin
		rx_ready_i <= drain;
		if (tx_valid_i && tx_ready_o) ti <= ti + 2'h1;
		tx_data_i <= rdv[ti];
		if (rx_valid_o && rx_ready_i) got.push_back(rx_data_o);
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			err_count++;
			complete_run();
		end
	end
	task complete_run;
		if (err_count == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : complete_run
	task t_mismatch;
		logic a;
		m.start();
		m.wr_byte({OWN_ADDR ^ 7'h01, 1'b0}, a);
		`CHK("addr_nak", 1'b1, a)
		m.wr_byte(8'h55, a);
		`CHK("data_nak", 1'b1, a)
		m.stop();
		`CHK("rx_idle", 1'b0, rx_valid_o)
	endtask : t_mismatch
	// Consumer stalls until the buffer refuses, then drains
	task t_write_stall;
		logic a;
		byte_t wd[3];
		wd = '{8'hA5, 8'h01, 8'hFF};
		fork
			begin
				m.start();
				m.wr_byte({OWN_ADDR, 1'b0}, a);
				`CHK("addr_ack", 1'b0, a)
				for (int i = 0; i < 3; i++) begin
					m.wr_byte(wd[i], a);
					`CHK("data_ack", 1'b0, a)
				end
				m.stop();
			end
			begin
				repeat (900) @(negedge clk_i);
				`CHK("stretch", 1'b1, scl_oe_o)
				drain <= 1'b1;
			end
		join
		repeat (40) @(negedge clk_i);
		`CHK("rx_count", 3, got.size())
		for (int i = 0; i < 3; i++) begin
			`CHK("rx_byte", wd[i], got[i])
		end
	endtask : t_write_stall
	// Source offers nothing at first, so the clock must stay stretched
	task t_read;
		logic a;
		byte_t d;
		fork
			begin
				m.start();
				m.wr_byte({OWN_ADDR, 1'b1}, a);
				`CHK("rd_ack", 1'b0, a)
				for (int i = 0; i < 3; i++) begin
					m.rd_byte(i == 2, d);
					`CHK("rd_byte", rdv[i], d)
				end
				`CHK("nak_free", 1'b1, sda_w)
				m.stop();
				`CHK("rd_idle", 1'b0, busy_o)
			end
			begin
				repeat (400) @(negedge clk_i);
				`CHK("tx_stretch", 1'b1, scl_oe_o)
				`CHK("tx_offer", 1'b1, tx_ready_o)
				@(posedge clk_i);
				tx_valid_i <= 1'b1;
			end
		join
	endtask : t_read
	initial begin
		resetn_i = 1'b0;
		drain = 1'b0;
		ti = 2'h0;
		tx_valid_i = 1'b0;
		tx_data_i = 8'h80;
		rx_ready_i = 1'b0;
		addr_i = OWN_ADDR;
		cyc = 0;
		repeat (16) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		t_mismatch();
		t_write_stall();
		t_read();
		complete_run();
	end
endmodule : testbench
